// >>> bench/rpv_checker.sv
// Purpose: port checks for the pin enable and voltage select block
// Assumes: one clock, rst async high
// Notes: sees outputs only through ports
`default_nettype none
module rpv_checker (
   // clock, reset, register port
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   // settings and pins
   input wire logic [2:0] regulator_sequence_slot,
   input wire logic [1:0] regulator_enable_field,
   input wire logic [7:0] multipurpose_control_pin,
   // regulator controls
   input wire logic pin_control_active,
   input wire logic pin_enable_request,
   input wire logic [5:0] applied_voltage_code
);
   timeunit 1ns / 1ns;
   wire mode = regulator_sequence_slot == 3'h7 && regulator_enable_field == 2'h2;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd(a);
      reg_read && reg_addr == a;
   endsequence
   a_en_gate: assert property (pin_enable_request |-> pin_control_active) else $error("enable off mode");
   a_mode_decode: assert property (1 |=> pin_control_active == $past(mode)) else $error("mode flag");
   a_no_pin_idle: assert property (multipurpose_control_pin == 8'h00 |=> !pin_enable_request) else $error("idle");
   a_read_back: assert property (s_rd(8'h3f) |=> reg_rdata == {2'h0, $past(applied_voltage_code)}) else $error("rb");
   a_cfg_upper: assert property (s_rd(8'h3a) |=> reg_rdata[7:5] == 3'h0) else $error("cfg bits");
   a_code_upper: assert property (reg_read && reg_addr > 8'h3a && reg_addr < 8'h40 |=> reg_rdata[7:6] == 2'h0)
      else $error("code bits");
   a_unmapped_zero: assert property (reg_read && (reg_addr < 8'h39 || reg_addr > 8'h3f) |=> reg_rdata == 8'h00)
      else $error("unmapped");
   a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule
bind rpv_regulator_pin_vsel rpv_checker u_chk (.*);
`default_nettype wire

// >>> bench/rpv_host_pins.sv
// Purpose: host side driving the control pins
// Assumes: levels change just after the sampling edge
// Notes: plain levels, no pull on these lines
`default_nettype none
module rpv_host_pins (
   input wire logic clk,
   input wire logic [7:0] want,
   output var logic [7:0] pins
);
   timeunit 1ns / 1ns;
   always @(posedge clk) pins <= want;
endmodule
`default_nettype wire

// >>> bench/rpv_regulator_pin_vsel_tb.sv
// Purpose: register and pin tests for the voltage select block
// Assumes: inputs move at the falling edge
// Notes: two falling edges cover pin and register lag
`default_nettype none
module rpv_regulator_pin_vsel_tb;
   timeunit 1ns / 1ns;
   logic clk = 0, rst = 1, wr = 0, rd = 0, sw = 0, act, req;
   logic [7:0] ad = 0, wd = 0, rdt, want = 0, pins;
   logic [2:0] slot = 0;
   logic [1:0] en = 0;
   logic [5:0] nv = 6'h2a, sv = 6'h11, av;
   int miscompares = 0, n_compared = 0, k, s;
   rpv_regulator_pin_vsel dut_u (.clk(clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd), .reg_write(wr), .reg_read(rd),
      .reg_rdata(rdt), .regulator_sequence_slot(slot), .regulator_enable_field(en), .normal_voltage_code(nv),
      .serial_voltage_write(sw), .serial_voltage_code(sv), .multipurpose_control_pin(pins),
      .pin_control_active(act), .pin_enable_request(req), .applied_voltage_code(av));
   rpv_host_pins host_u (.clk(clk), .want(want), .pins(pins));
   initial forever #50 clk = ~clk;
   task automatic chk(string n, logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   task automatic write(logic [7:0] a, d);
      @(negedge clk) {ad, wd, wr} = {a, d, 1'b1};
      @(negedge clk) wr = 0;
   endtask
   task automatic read(logic [7:0] a, exp);
      @(negedge clk) {ad, rd} = {a, 1'b1};
      @(negedge clk) rd = 0;
      chk("rdata", rdt, exp);
   endtask
   task automatic finish_test();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 0;
      for (k = 8'h39; k < 8'h3f; k++) read(k[7:0], 8'h00);
      for (k = 0; k < 4; k++) write(8'h3b + k[7:0], 8'hfc + k[7:0]);
      for (k = 0; k < 4; k++) read(8'h3b + k[7:0], 8'h3c + k[7:0]);
      write(8'h3a, 8'hff);
      write(8'h3f, 8'h00);
      read(8'h3a, 8'h1f);
      read(8'h3f, 8'h2a);
      read(8'h40, 8'h00);
      write(8'h3a, 8'h00);
      settle();
      chk("normal", {2'h0, av}, 8'h2a);
      write(8'h3a, 8'h1d);
      @(negedge clk) sw = 1;
      @(negedge clk) sw = 0;
      settle();
      read(8'h3f, 8'h11);
      k = 0;
      for (int p = 0; p < 7; p++)
         for (int q = p + 1; q < 8; q++) begin
            k++;
            write(8'h3a, k[7:0]);
            for (s = 0; s < 4; s++) begin
               want = 8'h00;
               want[p] = s[1];
               want[q] = s[0];
               settle();
               chk("code", {2'h0, av}, 8'h3c + s[7:0]);
            end
         end
      write(8'h39, 8'h24);
      {slot, en} = 5'h1e;
      for (k = 0; k < 8; k++) begin
         want = 8'h01 << k;
         settle();
         chk("enable", {7'h0, req}, {7'h0, k == 2 || k == 5});
      end
      want = 8'h00;
      settle();
      chk("idle", {7'h0, req}, 8'h00);
      want = 8'h24;
      for (k = 0; k < 5; k++) begin
         {slot, en} = k < 4 ? {3'h7, k[1:0]} : 5'h1a;
         settle();
         chk("mode", {6'h0, act, req}, k == 2 ? 8'h03 : 8'h00);
      end
      @(negedge clk) rst = 1;
      @(negedge clk) rst = 0;
      read(8'h39, 8'h00);
      read(8'h3f, 8'h2a);
      finish_test();
   end
   initial begin
      repeat (20000) @(negedge clk);
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire

// >>> core/rpv_map.vh
// Purpose: register offsets, field positions and reset values of the pin-driven enable and voltage-select block
// Assumes: 8-bit register port, one aligned byte per offset
// Notes: definitions only
`ifndef RPV_MAP_VH
`define RPV_MAP_VH

`define RPV_ADDR_PIN_ENABLE_SELECT 8'h39
`define RPV_ADDR_PIN_PAIR_DVS_CONFIG 8'h3a
`define RPV_ADDR_ALT_VOLTAGE_CODE_0 8'h3b
`define RPV_ADDR_ALT_VOLTAGE_CODE_1 8'h3c
`define RPV_ADDR_ALT_VOLTAGE_CODE_2 8'h3d
`define RPV_ADDR_ALT_VOLTAGE_CODE_3 8'h3e
`define RPV_ADDR_SERIAL_READBACK 8'h3f

`define RPV_CFG_MSB 4
`define RPV_CODE_MSB 5

`define RPV_CFG_DISABLED 5'h00
`define RPV_CFG_PAIR_FIRST 5'h01
`define RPV_CFG_PAIR_LAST 5'h1c
`define RPV_CFG_SERIAL 5'h1d

`define RPV_SEQ_PIN_SLOT 3'h7
`define RPV_EN_PIN_MODE 2'h2

`define RPV_RST_PIN_SELECT 8'h00
`define RPV_RST_CFG 5'h00
`define RPV_RST_CODE 6'h00
`define RPV_RST_RDATA 8'h00

`endif

// >>> core/rpv_regulator_pin_vsel.v
// Purpose: pin-driven enable and dynamic voltage selection for the third buck regulator
// Assumes: control pins synchronous to clk; register port driven by the two-wire bus engine
// Notes: codes are 0.55V plus code times the step size; step size is decoded by the analog side
// Behaviour
// - pin-select bit n lets pin n enable
// - pin enable only when slot 111, enable 10
// - enable is OR of selected pins
// - 5-bit config, 00000 uses normal voltage setting
// - codes 1 to 28 pick ascending pin pairs
// - code 11101 serial control; above reserved
// - first alternate code, 6 bits, linear from 0.55V
// - 50mV step: 000000 base, 111111 top
// - pin state 01 applies second code
// - pin state 11 applies fourth code
// - serial mode reads back applied code
`include "rpv_map.vh"
`default_nettype none

module rpv_regulator_pin_vsel (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   // settings held elsewhere in the regulator block
   input wire [2:0] regulator_sequence_slot,
   input wire [1:0] regulator_enable_field,
   input wire [5:0] normal_voltage_code,
   // serial voltage commands
   input wire serial_voltage_write,
   input wire [5:0] serial_voltage_code,
   // pins
   input wire [7:0] multipurpose_control_pin,
   // regulator controls
   output reg pin_control_active,
   output reg pin_enable_request,
   output reg [5:0] applied_voltage_code
);

   reg [7:0] pin_enable_select_reg;
   reg [4:0] voltage_select_config_reg;
   reg [5:0] alt_voltage_code_zero_reg;
   reg [5:0] alt_voltage_code_one_reg;
   reg [5:0] alt_voltage_code_two_reg;
   reg [5:0] alt_voltage_code_three_reg;
   reg [5:0] serial_voltage_reg;
   reg [7:0] rdata_next;
   reg [5:0] applied_next;
   reg [1:0] pin_state;
   reg pin_ctl_next;
   reg pin_en_next;

   // {first pin, second pin} for a pair code; serial and reserved codes give pins 0/0, which nothing reads then
   function [5:0] pair_pins;
      input [4:0] code;
      begin
         case (code)
            5'h01: pair_pins = {3'h0, 3'h1};
            5'h02: pair_pins = {3'h0, 3'h2};
            5'h03: pair_pins = {3'h0, 3'h3};
            5'h04: pair_pins = {3'h0, 3'h4};
            5'h05: pair_pins = {3'h0, 3'h5};
            5'h06: pair_pins = {3'h0, 3'h6};
            5'h07: pair_pins = {3'h0, 3'h7};
            5'h08: pair_pins = {3'h1, 3'h2};
            5'h09: pair_pins = {3'h1, 3'h3};
            5'h0a: pair_pins = {3'h1, 3'h4};
            5'h0b: pair_pins = {3'h1, 3'h5};
            5'h0c: pair_pins = {3'h1, 3'h6};
            5'h0d: pair_pins = {3'h1, 3'h7};
            5'h0e: pair_pins = {3'h2, 3'h3};
            5'h0f: pair_pins = {3'h2, 3'h4};
            5'h10: pair_pins = {3'h2, 3'h5};
            5'h11: pair_pins = {3'h2, 3'h6};
            5'h12: pair_pins = {3'h2, 3'h7};
            5'h13: pair_pins = {3'h3, 3'h4};
            5'h14: pair_pins = {3'h3, 3'h5};
            5'h15: pair_pins = {3'h3, 3'h6};
            5'h16: pair_pins = {3'h3, 3'h7};
            5'h17: pair_pins = {3'h4, 3'h5};
            5'h18: pair_pins = {3'h4, 3'h6};
            5'h19: pair_pins = {3'h4, 3'h7};
            5'h1a: pair_pins = {3'h5, 3'h6};
            5'h1b: pair_pins = {3'h5, 3'h7};
            5'h1c: pair_pins = {3'h6, 3'h7};
            default: pair_pins = 6'h00;
         endcase
      end
   endfunction

   // first listed pin of the pair drives the upper state bit
   function [2:0] pair_first;
      input [4:0] code;
      reg [5:0] both;
      begin
         both = pair_pins(code);
         pair_first = both[5:3];
      end
   endfunction

   function [2:0] pair_second;
      input [4:0] code;
      reg [5:0] both;
      begin
         both = pair_pins(code);
         pair_second = both[2:0];
      end
   endfunction

   function any_selected;
      input [7:0] pins;
      input [7:0] sel;
      begin
         any_selected = |(pins & sel);
      end
   endfunction

   // voltage codes sit in the low six bits of a byte
   function [7:0] widen_code;
      input [5:0] code;
      begin
         widen_code = {2'h0, code};
      end
   endfunction

   always @* begin
      pin_ctl_next = (regulator_sequence_slot == `RPV_SEQ_PIN_SLOT) &&
                     (regulator_enable_field == `RPV_EN_PIN_MODE);
      pin_en_next = pin_ctl_next && any_selected(multipurpose_control_pin, pin_enable_select_reg);
   end

   always @* begin
      pin_state = {multipurpose_control_pin[pair_first(voltage_select_config_reg)],
                   multipurpose_control_pin[pair_second(voltage_select_config_reg)]};
      if (voltage_select_config_reg == `RPV_CFG_DISABLED) begin
         applied_next = normal_voltage_code;
      end else if (voltage_select_config_reg == `RPV_CFG_SERIAL) begin
         applied_next = serial_voltage_reg;
      end else if (voltage_select_config_reg > `RPV_CFG_SERIAL) begin
         // reserved codes: fall back to the normal setting rather than an undefined pair
         applied_next = normal_voltage_code;
      end else begin
         case (pin_state)
            2'b00: applied_next = alt_voltage_code_zero_reg;
            2'b01: applied_next = alt_voltage_code_one_reg;
            2'b10: applied_next = alt_voltage_code_two_reg;
            2'b11: applied_next = alt_voltage_code_three_reg;
            default: applied_next = alt_voltage_code_zero_reg;
         endcase
      end
   end

   always @* begin
      case (reg_addr)
         `RPV_ADDR_PIN_ENABLE_SELECT: rdata_next = pin_enable_select_reg;
         `RPV_ADDR_PIN_PAIR_DVS_CONFIG: rdata_next = {3'h0, voltage_select_config_reg};
         `RPV_ADDR_ALT_VOLTAGE_CODE_0: rdata_next = widen_code(alt_voltage_code_zero_reg);
         `RPV_ADDR_ALT_VOLTAGE_CODE_1: rdata_next = widen_code(alt_voltage_code_one_reg);
         `RPV_ADDR_ALT_VOLTAGE_CODE_2: rdata_next = widen_code(alt_voltage_code_two_reg);
         `RPV_ADDR_ALT_VOLTAGE_CODE_3: rdata_next = widen_code(alt_voltage_code_three_reg);
         `RPV_ADDR_SERIAL_READBACK: rdata_next = widen_code(applied_voltage_code);
         default: rdata_next = `RPV_RST_RDATA;
      endcase
   end

   // host-writable settings; writes to the readback address fall to the default and are dropped
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_enable_select_reg <= `RPV_RST_PIN_SELECT;
         voltage_select_config_reg <= `RPV_RST_CFG;
         alt_voltage_code_zero_reg <= `RPV_RST_CODE;
         alt_voltage_code_one_reg <= `RPV_RST_CODE;
         alt_voltage_code_two_reg <= `RPV_RST_CODE;
         alt_voltage_code_three_reg <= `RPV_RST_CODE;
      end else if (reg_write) begin
         case (reg_addr)
            `RPV_ADDR_PIN_ENABLE_SELECT: pin_enable_select_reg <= reg_wdata;
            `RPV_ADDR_PIN_PAIR_DVS_CONFIG: voltage_select_config_reg <= reg_wdata[`RPV_CFG_MSB:0];
            `RPV_ADDR_ALT_VOLTAGE_CODE_0: alt_voltage_code_zero_reg <= reg_wdata[`RPV_CODE_MSB:0];
            `RPV_ADDR_ALT_VOLTAGE_CODE_1: alt_voltage_code_one_reg <= reg_wdata[`RPV_CODE_MSB:0];
            `RPV_ADDR_ALT_VOLTAGE_CODE_2: alt_voltage_code_two_reg <= reg_wdata[`RPV_CODE_MSB:0];
            `RPV_ADDR_ALT_VOLTAGE_CODE_3: alt_voltage_code_three_reg <= reg_wdata[`RPV_CODE_MSB:0];
            default: ;
         endcase
      end
   end

   // setting loaded by the serial voltage command
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_voltage_reg <= `RPV_RST_CODE;
      end else if (serial_voltage_write) begin
         serial_voltage_reg <= serial_voltage_code;
      end
   end

   // read data holds until the next read strobe, so a slow bus engine can pick it up late
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `RPV_RST_RDATA;
      end else if (reg_read) begin
         reg_rdata <= rdata_next;
      end
   end

   // controls are registered so pin edges never reach the regulator as glitches
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_control_active <= 1'b0;
         pin_enable_request <= 1'b0;
         applied_voltage_code <= `RPV_RST_CODE;
      end else begin
         pin_control_active <= pin_ctl_next;
         pin_enable_request <= pin_en_next;
         applied_voltage_code <= applied_next;
      end
   end

endmodule

`default_nettype wire
